/* File: design/arc_top.v */
// Serial port, GPIO, clock selection and rate timing of the converter
// Overview of operation
// - Serial input bits are captured on rising serial clock edges.
// - Ready/data output drives low while a new result waits, else carries read data.
// - Ready/data output changes only on falling chip select and falling serial clock edges.
// - Chip select is active low; serial traffic is ignored while it is high.
// - External clock select bit takes the system clock from the external clock pin.
// - Data rate scales with whatever clock frequency is supplied.
// - Four general-purpose pins, direction and level set by a serial register.
// - Buffer bit in control register one enables or bypasses the input buffer.
// - Polarity bit selects unipolar or bipolar transfer function.
// - Line frequency bit picks 2.4576 MHz (clear) or 2.048 MHz (set) oscillator.
// - Sampling frequency is one tenth of the system clock.
// - Core clock runs the state machine; the system clock is divided for all timing.
// - Continuous codes 100..111 give 60..480 sps, or 50..400 sps.
// - Single-cycle codes 000..111 give 1..120 sps, or 0.833..100 sps.
// - Single-cycle bit clear means continuous, set means single-cycle conversion.
// - Rate field travels in the command byte, not in a control register.
`timescale 1ns/1ps
`include "arc_consts.vh"

module arc_top (
	// Clock and reset
	input wire i_clock,
	input wire i_rstn,
	// Serial port pins
	input wire i_sclk,
	input wire i_cs_n,
	input wire i_din,
	output reg o_rdy_dout,
	output reg o_rdy_dout_oe,
	// External system clock pin
	input wire i_ext_clock,
	// General-purpose pins
	input wire [3:0] i_gpio,
	output reg [3:0] o_gpio,
	output reg [3:0] o_gpio_oe,
	// Conversion results from the filter
	input wire [23:0] i_result_data,
	input wire i_result_valid,
	output reg o_result_ready,
	// Analog and timing controls
	output reg o_input_buffer_enable,
	output reg o_unipolar_select,
	output reg o_line_freq_select,
	output reg o_sample_tick,
	output reg o_conv_strobe,
	output reg o_conv_busy
);

	// Phase increments derived from the oscillator and core clock rates
	localparam [63:0] INC60_W = (64'd`ARC_OSC60_HZ << `ARC_ACC_W) / 64'd`ARC_CLK_HZ;
	localparam [63:0] INC50_W = (64'd`ARC_OSC50_HZ << `ARC_ACC_W) / 64'd`ARC_CLK_HZ;
	localparam [23:0] INC60 = INC60_W[23:0];
	localparam [23:0] INC50 = INC50_W[23:0];
	// Serial state machine codes
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_CMD = 2'h1;
	localparam [1:0] ST_WR = 2'h2;
	localparam [1:0] ST_RD = 2'h3;
	reg [7:0] sync1_r;
	reg [7:0] sync2_r;
	reg sclk_q_r;
	reg cs_q_r;
	reg ext_q_r;
	reg [7:0] control_reg_one_r;
	reg [7:0] gpio_ctrl_r;
	reg [23:0] acc_r;
	reg src_ext_r;
	reg [3:0] fs_cnt_r;
	reg [17:0] conv_cnt_r;
	reg [2:0] rate_r;
	reg scyc_r;
	reg [23:0] mem_r [0:1];
	reg wr_ptr_r;
	reg rd_ptr_r;
	reg [1:0] cnt_r;
	reg [1:0] cnt_nxt;
	reg [1:0] st_r;
	reg [4:0] bit_cnt_r;
	reg [7:0] sh_in_r;
	reg [23:0] sh_out_r;
	reg [2:0] addr_r;
	reg conv_go_r;
	reg [2:0] go_rate_r;
	reg pop_r;
	wire sclk_rise;
	wire sclk_fall;
	wire cs_low;
	wire cs_fall;
	wire ext_rise;
	wire [24:0] acc_sum;
	wire int_tick;
	wire sys_tick;
	wire samp_tick;
	wire push;
	wire pop;
	wire [7:0] cmd_byte;
	wire [17:0] period;
	// Conversion length in sampling ticks, so the rate follows the clock
	function [17:0] arc_period;
		input scyc;
		input [2:0] rate;
		begin
			case ({scyc, rate})
				4'h4: arc_period = `ARC_N_C4;
				4'h5: arc_period = `ARC_N_C5;
				4'h6: arc_period = `ARC_N_C6;
				4'h7: arc_period = `ARC_N_C7;
				4'h8: arc_period = `ARC_N_S0;
				4'h9: arc_period = `ARC_N_S1;
				4'ha: arc_period = `ARC_N_S2;
				4'hb: arc_period = `ARC_N_S3;
				4'hc: arc_period = `ARC_N_S4;
				4'hd: arc_period = `ARC_N_S5;
				4'he: arc_period = `ARC_N_S6;
				4'hf: arc_period = `ARC_N_S7;
				default: arc_period = `ARC_N_C4;
			endcase
		end
	endfunction
	// Two-stage synchronisers for every pin input
	always @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			sync1_r <= `ARC_SYNC_RST;
			sync2_r <= `ARC_SYNC_RST;
			sclk_q_r <= 1'b0;
			cs_q_r <= 1'b1;
			ext_q_r <= 1'b0;
		end else begin
			sync1_r <= {i_gpio, i_ext_clock, i_din, i_cs_n, i_sclk};
			sync2_r <= sync1_r;
			sclk_q_r <= sync2_r[0];
			cs_q_r <= sync2_r[1];
			ext_q_r <= sync2_r[3];
		end
	end
	// Edge detection on synchronised pins only
	assign cs_low = ~sync2_r[1];
	assign cs_fall = cs_low & cs_q_r;
	assign sclk_rise = cs_low & sync2_r[0] & ~sclk_q_r;
	assign sclk_fall = cs_low & ~sync2_r[0] & sclk_q_r;
	assign ext_rise = sync2_r[3] & ~ext_q_r;
	// Internal oscillator model: phase accumulator carry gives one tick per cycle
	assign acc_sum = {1'b0, acc_r} + {1'b0, control_reg_one_r[`ARC_C1_LINE_FREQ] ? INC50 : INC60};
	assign int_tick = acc_sum[24];
	assign sys_tick = src_ext_r ? ext_rise : int_tick;
	assign samp_tick = sys_tick & (fs_cnt_r == `ARC_FS_DIV - 4'h1);
	// Source is switched only on a tick of the old source, so no runt cycle
	always @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			acc_r <= 24'h000000;
			src_ext_r <= 1'b0;
			fs_cnt_r <= 4'h0;
			o_sample_tick <= 1'b0;
		end else begin
			acc_r <= acc_sum[23:0];
			if (sys_tick && (src_ext_r != control_reg_one_r[`ARC_C1_EXT])) begin
				src_ext_r <= control_reg_one_r[`ARC_C1_EXT];
			end
			if (sys_tick) begin
				fs_cnt_r <= samp_tick ? 4'h0 : fs_cnt_r + 4'h1;
			end
			o_sample_tick <= samp_tick;
		end
	end
	// Conversion timing: counts sampling ticks, so rate scales with the clock
	assign period = arc_period(scyc_r, rate_r);
	always @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			conv_cnt_r <= 18'h00000;
			rate_r <= 3'h0;
			scyc_r <= 1'b1;
			o_conv_busy <= 1'b0;
			o_conv_strobe <= 1'b0;
		end else begin
			o_conv_strobe <= 1'b0;
			if (conv_go_r) begin
				rate_r <= go_rate_r;
				scyc_r <= control_reg_one_r[`ARC_C1_SCYC];
				conv_cnt_r <= 18'h00000;
				o_conv_busy <= 1'b1;
			end else if (o_conv_busy && samp_tick) begin
				if (conv_cnt_r == period - 18'h00001) begin
					conv_cnt_r <= 18'h00000;
					o_conv_strobe <= 1'b1;
					if (scyc_r) begin
						o_conv_busy <= 1'b0;
					end
				end else begin
					conv_cnt_r <= conv_cnt_r + 18'h00001;
				end
			end
		end
	end
	// Two-entry result buffer; a full buffer holds off the filter
	assign push = i_result_valid & o_result_ready;
	assign pop = pop_r & (cnt_r != 2'h0);
	always @* begin
		cnt_nxt = cnt_r;
		if (push && !pop) begin
			cnt_nxt = cnt_r + 2'h1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 2'h1;
		end
	end
	// Storage and occupancy; ready is registered, so it frees one cycle after a pop
	always @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			cnt_r <= 2'h0;
			o_result_ready <= 1'b1;
			mem_r[0] <= 24'h000000;
			mem_r[1] <= 24'h000000;
		end else begin
			if (push) begin
				mem_r[wr_ptr_r] <= i_result_data;
				wr_ptr_r <= ~wr_ptr_r;
			end
			if (pop) begin
				rd_ptr_r <= ~rd_ptr_r;
			end
			cnt_r <= cnt_nxt;
			o_result_ready <= (cnt_nxt != 2'h2);
		end
	end

	// Serial engine: commands, register access and ready/data output
	assign cmd_byte = {sh_in_r[6:0], sync2_r[2]};
	always @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			st_r <= ST_IDLE;
			bit_cnt_r <= 5'h00;
			sh_in_r <= 8'h00;
			sh_out_r <= 24'h000000;
			addr_r <= 3'h0;
			conv_go_r <= 1'b0;
			go_rate_r <= 3'h0;
			pop_r <= 1'b0;
			control_reg_one_r <= `ARC_C1_RST;
			gpio_ctrl_r <= `ARC_GPIO_RST;
			o_rdy_dout <= 1'b1;
			o_rdy_dout_oe <= 1'b0;
		end else begin
			conv_go_r <= 1'b0;
			pop_r <= 1'b0;
			if (!cs_low) begin
				st_r <= ST_IDLE;
				o_rdy_dout_oe <= 1'b0;
			end else if (cs_fall) begin
				st_r <= ST_CMD;
				bit_cnt_r <= 5'h00;
				o_rdy_dout <= (cnt_r == 2'h0);
				o_rdy_dout_oe <= 1'b1;
			end else begin
				// Output moves on falling edges so the host samples on rising ones
				if (sclk_fall) begin
					if (st_r == ST_RD) begin
						o_rdy_dout <= sh_out_r[23];
						sh_out_r <= {sh_out_r[22:0], 1'b0};
					end else begin
						o_rdy_dout <= (cnt_r == 2'h0);
					end
				end
				if (sclk_rise) begin
					sh_in_r <= cmd_byte;
					bit_cnt_r <= bit_cnt_r + 5'h01;
					case (st_r)
						ST_CMD: begin
							if (bit_cnt_r == `ARC_LAST_BYTE) begin
								bit_cnt_r <= 5'h00;
								addr_r <= cmd_byte[3:1];
								if (!cmd_byte[`ARC_CMD_START]) begin
									st_r <= ST_IDLE;
								end else if (!cmd_byte[`ARC_CMD_REG]) begin
									conv_go_r <= 1'b1;
									go_rate_r <= cmd_byte[2:0];
									st_r <= ST_IDLE;
								end else if (cmd_byte[`ARC_CMD_RW]) begin
									st_r <= ST_RD;
									case (cmd_byte[3:1])
										`ARC_ADDR_CTRL_ONE: sh_out_r <= {control_reg_one_r, 16'h0000};
										`ARC_ADDR_GPIO: sh_out_r <= {gpio_ctrl_r[7:4], sync2_r[7:4], 16'h0000};
										`ARC_ADDR_DATA: sh_out_r <= (cnt_r == 2'h0) ? 24'h000000 : mem_r[rd_ptr_r];
										`ARC_ADDR_STAT: sh_out_r <= {cnt_r, o_conv_busy, scyc_r, src_ext_r, rate_r, 16'h0000};
										default: sh_out_r <= 24'h000000;
									endcase
								end else begin
									st_r <= ST_WR;
								end
							end
						end
						ST_WR: begin
							if (bit_cnt_r == `ARC_LAST_BYTE) begin
								st_r <= ST_IDLE;
								if (addr_r == `ARC_ADDR_CTRL_ONE) begin
									control_reg_one_r <= cmd_byte & `ARC_C1_MASK;
								end else if (addr_r == `ARC_ADDR_GPIO) begin
									gpio_ctrl_r <= cmd_byte;
								end
							end
						end
						ST_RD: begin
							if (bit_cnt_r == ((addr_r == `ARC_ADDR_DATA) ? `ARC_LAST_DATA : `ARC_LAST_BYTE)) begin
								st_r <= ST_IDLE;
								pop_r <= (addr_r == `ARC_ADDR_DATA);
							end
						end
						default: begin
							st_r <= ST_IDLE;
						end
					endcase
				end
			end
		end
	end

	// Configuration fields to the analog side and GPIO pins, all registered
	always @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_input_buffer_enable <= 1'b0;
			o_unipolar_select <= 1'b0;
			o_line_freq_select <= 1'b0;
			o_gpio <= 4'h0;
			o_gpio_oe <= 4'h0;
		end else begin
			o_input_buffer_enable <= control_reg_one_r[`ARC_C1_BUF];
			o_unipolar_select <= control_reg_one_r[`ARC_C1_UNI];
			o_line_freq_select <= control_reg_one_r[`ARC_C1_LINE_FREQ];
			o_gpio <= gpio_ctrl_r[3:0];
			o_gpio_oe <= gpio_ctrl_r[7:4];
		end
	end

endmodule

/* File: inc/arc_consts.vh */
// Constants for the converter rate and clock control block
`ifndef ARC_CONSTS_VH
`define ARC_CONSTS_VH

// Clock rates in Hz and phase accumulator width
`define ARC_CLK_HZ 40000000
`define ARC_OSC60_HZ 2457600
`define ARC_OSC50_HZ 2048000
`define ARC_ACC_W 24

// Sampling clock is the system clock divided by ten
`define ARC_FS_DIV 4'ha

// Command byte fields
`define ARC_CMD_START 7
`define ARC_CMD_REG 6
`define ARC_CMD_RW 0

// Register addresses carried in the command byte
`define ARC_ADDR_CTRL_ONE 3'h0
`define ARC_ADDR_GPIO 3'h1
`define ARC_ADDR_DATA 3'h2
`define ARC_ADDR_STAT 3'h3

// Fields, write mask and reset value of control_reg_one, then GPIO and synchroniser reset values
`define ARC_C1_SCYC 1
`define ARC_C1_BUF 3
`define ARC_C1_EXT 5
`define ARC_C1_UNI 6
`define ARC_C1_LINE_FREQ 7
`define ARC_C1_MASK 8'hea
`define ARC_C1_RST 8'h02
`define ARC_GPIO_RST 8'h00
`define ARC_SYNC_RST 8'h02

// Serial frame lengths, last bit index
`define ARC_LAST_BYTE 5'h07
`define ARC_LAST_DATA 5'h17

// Conversion periods in sampling ticks, continuous mode
`define ARC_N_C4 18'h01000
`define ARC_N_C5 18'h00800
`define ARC_N_C6 18'h00400
`define ARC_N_C7 18'h00200

// Conversion periods in sampling ticks, single-cycle mode
`define ARC_N_S0 18'h3c000
`define ARC_N_S1 18'h18000
`define ARC_N_S2 18'h0c000
`define ARC_N_S3 18'h06000
`define ARC_N_S4 18'h04000
`define ARC_N_S5 18'h02000
`define ARC_N_S6 18'h01000
`define ARC_N_S7 18'h00800

`endif

/* File: sim/arc_host.sv */
// Serial host model driving frames into the converter
`timescale 1ns/1ps
module arc_host (
	// Core clock
	input wire i_clock,
	// Serial pins
	input wire i_rdy_dout,
	output reg o_sclk,
	output reg o_cs_n,
	output reg o_din
);
	int half = 6; // Core cycles per serial phase, raise it to run slowly
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_din = 1'b0;
	end
	// Frame of nb bits, MSB first; rx collects the data pin at each rise
	task automatic frame(input int nb, input logic [31:0] tx, output logic [31:0] rx);
		rx = 32'h0;
		@(posedge i_clock);
		o_cs_n <= 1'b0;
		repeat (half) @(posedge i_clock);
		for (int b = nb - 1; b >= 0; b--) begin
			o_din <= tx[b];
			repeat (half) @(posedge i_clock);
			o_sclk <= 1'b1;
			rx = {rx[30:0], i_rdy_dout};
			repeat (half) @(posedge i_clock);
			o_sclk <= 1'b0;
		end
		repeat (half) @(posedge i_clock);
		o_cs_n <= 1'b1;
		o_din <= ~o_din; // Released line carries no stale bit
		repeat (2 * half) @(posedge i_clock);
	endtask
endmodule

/* File: sim/arc_top_assertions.sv */
// Port timing checker for the converter rate and clock control block
`timescale 1ns/1ps
module arc_top_checker (
	// Clock, reset and serial pins
	input wire i_clock,
	input wire i_rstn,
	input wire i_sclk,
	input wire i_cs_n,
	input wire o_rdy_dout,
	input wire o_rdy_dout_oe,
	// Result stream
	input wire i_result_valid,
	input wire o_result_ready,
	// Controls, pins and timing
	input wire [3:0] o_gpio,
	input wire [3:0] o_gpio_oe,
	input wire o_input_buffer_enable,
	input wire o_unipolar_select,
	input wire o_line_freq_select,
	input wire o_sample_tick,
	input wire o_conv_strobe,
	input wire o_conv_busy
);
	// One clock domain, so clock and reset are set once
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	oe_in_frame_a: assert property (!i_cs_n [*7] |-> o_rdy_dout_oe)
		else $error("data pin not driven in frame");
	oe_idle_a: assert property (i_cs_n [*7] |-> !o_rdy_dout_oe)
		else $error("data pin driven while deselected");
	// Settled high serial clock: only falls may move the data pin
	rdy_fall_only_a: assert property ((i_sclk && !i_cs_n && $stable(i_sclk) && $stable(i_cs_n)) [*5]
		|-> $stable(o_rdy_dout))
		else $error("data pin moved while serial clock high");
	tick_gap_a: assert property (o_sample_tick |=> !o_sample_tick [*8])
		else $error("sample ticks too close");
	strobe_busy_a: assert property (o_conv_strobe |-> $past(o_conv_busy))
		else $error("strobe without running conversion");
	conv_gap_a: assert property ($rose(o_conv_busy) |=> !o_conv_strobe [*8])
		else $error("conversion ended too early");
	buf_full_a: assert property ((o_result_ready && i_result_valid && i_cs_n) [*2] |=> !o_result_ready)
		else $error("buffer took a third word");
	full_hold_a: assert property (i_cs_n [*8] ##0 !o_result_ready |=> !o_result_ready)
		else $error("buffer freed without a read");
	gpio_hold_a: assert property (i_cs_n [*8] |=> $stable(o_gpio) && $stable(o_gpio_oe))
		else $error("pins changed without a write");
	ctrl_hold_a: assert property (i_cs_n [*8]
		|=> $stable({o_input_buffer_enable, o_unipolar_select, o_line_freq_select}))
		else $error("controls changed without a write");
endmodule
bind arc_top arc_top_checker arc_top_checker_i (.i_clock, .i_rstn, .i_sclk, .i_cs_n, .o_rdy_dout,
	.o_rdy_dout_oe, .i_result_valid, .o_result_ready, .o_gpio, .o_gpio_oe, .o_input_buffer_enable,
	.o_unipolar_select, .o_line_freq_select, .o_sample_tick, .o_conv_strobe, .o_conv_busy);

/* File: sim/arc_top_test.sv */
// Self-checking bench for the converter rate and clock control block
`timescale 1ns/1ps
module arc_top_test;
	reg clk = 0, rstn = 0, ext = 0, valid = 0;
	reg [3:0] gpio_in = 4'h0;
	reg [23:0] rdata = 24'h0;
	reg [31:0] lfsr = 32'h9fc1b347, rx, exp;
	reg [7:0] v;
	wire sclk, cs_n, din, rdy, rdy_oe, rready, buf_en, uni, line_freq, tick, strobe, busy;
	wire [3:0] gpio, gpio_oe;
	int fail_count = 0, total_checks = 0, c;
	logic [23:0] q[$];
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) ext <= ~ext; // Fast external clock keeps conversions short
	arc_top arc_top_i (.i_clock(clk), .i_rstn(rstn), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
		.o_rdy_dout(rdy), .o_rdy_dout_oe(rdy_oe), .i_ext_clock(ext), .i_gpio(gpio_in), .o_gpio(gpio),
		.o_gpio_oe(gpio_oe), .i_result_data(rdata), .i_result_valid(valid), .o_result_ready(rready),
		.o_input_buffer_enable(buf_en), .o_unipolar_select(uni), .o_line_freq_select(line_freq),
		.o_sample_tick(tick), .o_conv_strobe(strobe), .o_conv_busy(busy));
	arc_host arc_host_i (.i_clock(clk), .i_rdy_dout(rdy_oe ? rdy : ~rdy), .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));
	function automatic [31:0] next_rand(input [31:0] s);
		next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic int near(input int got, input int want);
		near = (got >= want - 2) && (got <= want + 2);
	endfunction
	task automatic check(input [31:0] got, input [31:0] want);
		total_checks++;
		if (got !== want) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	// Core cycles over ten ticks, after the clock source has settled
	task automatic tick_span(output int cyc);
		int t;
		repeat (400) @(posedge clk);
		@(posedge clk iff tick);
		cyc = 0;
		t = 0;
		while (t < 10) begin
			@(posedge clk);
			cyc++;
			if (tick) t++;
		end
	endtask
	// Ticks up to a strobe, from now or from the previous strobe
	task automatic conv_span(input bit from_now, output int t);
		if (!from_now) @(posedge clk iff strobe);
		t = 0;
		do begin
			@(posedge clk);
			if (tick) t++;
		end while (!strobe);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		for (int k = 0; k < 6; k++) begin
			lfsr = next_rand(lfsr);
			v = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : lfsr[7:0];
			arc_host_i.frame(16, {8'hc0, v}, rx);
			check({line_freq, uni, buf_en}, {v[7], v[6], v[3]});
			arc_host_i.frame(16, 16'hc100, rx);
			check(rx[7:0], v & 8'hea);
		end
		arc_host_i.frame(12, 12'hc0f, rx);
		check({line_freq, uni, buf_en}, {v[7], v[6], v[3]});
		// A command without its start bit must leave everything alone
		arc_host_i.frame(16, {8'h40, ~v}, rx);
		check({line_freq, uni, buf_en}, {v[7], v[6], v[3]});
		$display("control test finished");
		gpio_in <= lfsr[3:0];
		arc_host_i.frame(16, {8'hc2, 8'ha6}, rx);
		check({gpio_oe, gpio}, 8'ha6);
		arc_host_i.frame(16, 16'hc300, rx);
		check(rx[7:0], {4'ha, gpio_in});
		arc_host_i.frame(16, {8'hca, 8'h5f}, rx);
		arc_host_i.frame(16, 16'hcb00, rx);
		check({rx[7:0], gpio_oe, gpio}, 16'h00a6);
		$display("pin test finished");
		valid <= 1'b1;
		repeat (4) begin
			lfsr = next_rand(lfsr);
			rdata <= lfsr[23:0];
			@(posedge clk);
			if (rready) q.push_back(rdata);
		end
		valid <= 1'b0;
		check(q.size(), 2);
		arc_host_i.half = 12;
		repeat (3) begin
			exp = q.size() ? {8'h00, q.pop_front()} : 32'hff000000;
			arc_host_i.frame(32, 32'hc5000000, rx);
			check(rx, exp);
		end
		arc_host_i.half = 6;
		check(rready, 1);
		$display("buffer test finished");
		arc_host_i.frame(16, 16'hc000, rx);
		tick_span(c);
		check(near(c, 400000000 / 245760), 1);
		arc_host_i.frame(16, 16'hc080, rx);
		tick_span(c);
		check(near(c, 400000000 / 204800), 1);
		arc_host_i.frame(16, 16'hc020, rx);
		tick_span(c);
		check(c, 400000000 / 2000000);
		$display("clock test finished");
		for (int k = 0; k < 8; k++) begin
			arc_host_i.frame(8, 8'h80 | k, rx);
			check(busy, 1);
		end
		// Status: empty buffer, busy, continuous, external source, rate seven
		arc_host_i.frame(16, 16'hc700, rx);
		check(rx[7:0], 8'h2f);
		conv_span(0, c);
		check(c, 512);
		check(busy, 1);
		arc_host_i.frame(16, 16'hc022, rx);
		arc_host_i.frame(8, 8'h87, rx);
		conv_span(1, c);
		check(near(c, 2048), 1);
		repeat (40) @(posedge clk);
		check(busy, 0);
		$display("conversion test finished");
		final_report;
	end
	// Watchdog beyond the roughly 76000 cycles the tests need, yet short of a runaway run
	initial begin
		repeat (95000) @(posedge clk);
		fail_count++;
		final_report;
	end
endmodule
